// ==== inc/fvec_pkg.sv ====
// constants shared by the feature configuration block
package fvec_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [4:0] ADDR_CDW11 = 5'h00;
  localparam logic [4:0] ADDR_CMD = 5'h04;
  localparam logic [4:0] ADDR_STAT = 5'h08;
  localparam logic [4:0] ADDR_DW0 = 5'h0c;
  localparam logic [4:0] ADDR_ATOM = 5'h10;
  localparam logic [4:0] ADDR_AEN = 5'h14;

  // ----------------------------------------
  // feature identifiers
  // ----------------------------------------
  localparam logic [7:0] FID_VEC_CFG = 8'h09;
  localparam logic [7:0] FID_ATOMIC = 8'h0a;
  localparam logic [7:0] FID_ASYNC_EVT = 8'h0b;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_SET_BIT = 1;
  localparam int CMD_FID_LSB = 8;
  localparam int FID_W = 8;
  localparam int COAL_OFF_BIT = 16;
  localparam int VEC_IDX_W = 16;
  localparam int NAO_BIT = 0;
  localparam int AEN_CW_W = 8;
  localparam int AEN_NS_BIT = 8;
  localparam int AEN_FW_BIT = 9;
  localparam int AEN_W = 10;

  // ----------------------------------------
  // status codes and reset values
  // ----------------------------------------
  localparam logic [7:0] SC_SUCCESS = 8'h00;
  localparam logic [7:0] SC_INV_FIELD = 8'h02;
  localparam logic COAL_OFF_RST = 1'b0;
  localparam logic NAO_RST = 1'b0;
  localparam logic [AEN_W-1:0] AEN_RST = 10'h000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int COAL_UNIT_US = 100;
  localparam int COAL_UNIT_CYCLES = COAL_UNIT_US * CLK_MHZ;

  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} fvec_state_t;

endpackage : fvec_pkg

// ==== design/fvec_vec_table.sv ====
// per-vector coalescing disable store with validity lookup
`timescale 1ns/1ps
module fvec_vec_table #(
  parameter int NUM_VEC = 32,
  parameter int IW = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // write port
  input wire logic wr_en,
  input wire logic [IW-1:0] wr_idx,
  input wire logic wr_off,
  // command lookup
  input wire logic [IW-1:0] rd_idx_a,
  input wire logic [NUM_VEC-1:0] cq_ok,
  output logic a_off,
  output logic a_valid,
  // interrupt lookup
  input wire logic [IW-1:0] rd_idx_b,
  output logic b_off
);
  import fvec_pkg::*;

  localparam int SW = (NUM_VEC > 1) ? $clog2(NUM_VEC) : 1;
  localparam logic [IW:0] LIMIT = (IW+1)'(NUM_VEC);

  logic [NUM_VEC-1:0] off_bits;

  wire in_a = {1'b0, rd_idx_a} < LIMIT;
  wire in_b = {1'b0, rd_idx_b} < LIMIT;
  wire in_w = {1'b0, wr_idx} < LIMIT;
  wire [SW-1:0] sel_a = rd_idx_a[SW-1:0];
  wire [SW-1:0] sel_b = rd_idx_b[SW-1:0];
  wire [SW-1:0] sel_w = wr_idx[SW-1:0];

  // out-of-range vectors read as coalesced and invalid
  assign a_off = in_a & off_bits[sel_a];
  assign a_valid = in_a & cq_ok[sel_a];
  assign b_off = in_b & off_bits[sel_b];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      off_bits <= {NUM_VEC{COAL_OFF_RST}};
    end else if (ce && wr_en && in_w) begin
      off_bits[sel_w] <= wr_off;
    end
  end

endmodule : fvec_vec_table

// ==== design/fvec_event_gate.sv ====
// gates asynchronous event sources with the stored enables
`timescale 1ns/1ps
module fvec_event_gate #(
  parameter int CW = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // enables
  input wire logic fw_en,
  input wire logic ns_en,
  input wire logic [CW-1:0] cw_en,
  // event sources
  input wire logic fw_evt,
  input wire logic ns_evt,
  input wire logic [CW-1:0] cw_level,
  // gated notices
  output logic fw_notice,
  output logic ns_notice,
  output logic [CW-1:0] cw_notice
);
  // a warning already high when its enable is set does not notify;
  // only a fresh rise does
  logic [CW-1:0] cw_prev;
  wire [CW-1:0] cw_rise = cw_level & ~cw_prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cw_prev <= '0;
      fw_notice <= 1'b0;
      ns_notice <= 1'b0;
      cw_notice <= '0;
    end else if (ce) begin
      cw_prev <= cw_level;
      fw_notice <= fw_evt & fw_en;
      ns_notice <= ns_evt & ns_en;
      cw_notice <= cw_rise & cw_en;
    end
  end

endmodule : fvec_event_gate

// ==== design/fvec_top.sv ====
// feature configuration command interpreter with axi4-lite access
//
// What this block does
// - feature 09h is per-vector interrupt configuration, taken from dword 11.
// - after reset every vector has coalescing enabled.
// - admin completion queue interrupts are never coalesced.
// - get 09h returns the named vector's disable bit and index in dword 0.
// - invalid vector or queue completes with invalid field in command.
// - bit 16 set means no coalescing delay for this vector.
// - bits 15:0 hold the vector index; bits 31:17 are reserved.
// - feature 0Ah is atomicity mode; bit 0 disables normal atomicity.
// - disable at one honours power-fail limits only; zero honours both.
// - get 0Ah returns the stored disable flag in dword 0.
// - feature 0Bh is async event enables; bits 31:10 reserved.
// - clearing an enable suppresses a persistent condition's reports.
// - get 0Bh returns all stored event enables in dword 0.
// - bit 9 gates firmware activation starting notices.
// - bit 8 gates namespace attribute changed notices.
// - bits 7:0 gate notices for each rising critical warning bit.
// - coalescing delay is time field times 100 us; zero means none.
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module fvec_top #(
  parameter int NUM_VEC = 32,
  parameter int UNIT_CYCLES = fvec_pkg::COAL_UNIT_CYCLES
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [4:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [4:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // queue manager view of vectors
  input wire logic [NUM_VEC-1:0] vec_cq_ok,
  // interrupt requests from completion logic
  input wire logic int_req,
  input wire logic [fvec_pkg::VEC_IDX_W-1:0] int_vec,
  input wire logic int_admin,
  input wire logic [7:0] agg_time,
  // interrupt decision
  output logic int_go,
  output logic [fvec_pkg::VEC_IDX_W-1:0] int_go_vec,
  output logic int_now,
  output logic [31:0] int_hold_cycles,
  // atomicity mode
  output logic normal_atomic_off,
  output logic honour_normal_atomic,
  // event sources
  input wire logic fw_act_evt,
  input wire logic ns_attr_evt,
  input wire logic [fvec_pkg::AEN_CW_W-1:0] crit_warn,
  // gated event notices
  output logic fw_act_notice,
  output logic ns_attr_notice,
  output logic [fvec_pkg::AEN_CW_W-1:0] crit_notice
);
  import fvec_pkg::*;

  localparam logic [31:0] UNIT_32 = 32'(UNIT_CYCLES);

  // ----------------------------------------
  // byte lane merge
  // ----------------------------------------
  function automatic logic [31:0] fvec_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : fvec_merge

  // ----------------------------------------
  // state
  // ----------------------------------------
  fvec_state_t state;
  logic [31:0] cdw11;
  logic cmd_set;
  logic [FID_W-1:0] cmd_fid;
  logic done;
  logic [7:0] sc;
  logic [31:0] dw0;
  logic [AEN_W-1:0] aen;
  logic [4:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // ----------------------------------------
  // write channel decode
  // ----------------------------------------
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  // write lands once address and data are both held and no answer waits
  wire wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire b_take = s_axi_bvalid & s_axi_bready;
  wire [4:0] wa = {aw_addr_q[4:2], 2'b00};
  wire wa_cdw11 = (wa == ADDR_CDW11);
  wire wa_cmd = (wa == ADDR_CMD);
  wire wa_ro = (wa == ADDR_STAT) | (wa == ADDR_DW0) | (wa == ADDR_ATOM) | (wa == ADDR_AEN);
  wire wa_bad = ~(wa_cdw11 | wa_cmd | wa_ro);
  wire wr_cdw11 = wr_fire & wa_cdw11;
  wire wr_go = wr_fire & wa_cmd & w_strb_q[0] & w_data_q[CMD_GO_BIT];
  // a go while a command executes is dropped
  wire start = wr_go & (state == ST_IDLE);
  wire [31:0] cdw11_merged = fvec_merge(cdw11, w_data_q, w_strb_q);

  // ----------------------------------------
  // read channel decode
  // ----------------------------------------
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire r_take = s_axi_rvalid & s_axi_rready;
  wire [4:0] ra = {s_axi_araddr[4:2], 2'b00};
  wire ra_cdw11 = (ra == ADDR_CDW11);
  wire ra_cmd = (ra == ADDR_CMD);
  wire ra_stat = (ra == ADDR_STAT);
  wire ra_dw0 = (ra == ADDR_DW0);
  wire ra_atom = (ra == ADDR_ATOM);
  wire ra_aen = (ra == ADDR_AEN);
  wire ra_bad = ~(ra_cdw11 | ra_cmd | ra_stat | ra_dw0 | ra_atom | ra_aen);
  wire exec = (state == ST_EXEC);
  wire [31:0] cmd_view = {16'h0000, cmd_fid, 6'h00, cmd_set, exec};
  wire [31:0] stat_view = {16'h0000, sc, 6'h00, exec, done};
  wire [31:0] rd_data = ra_cdw11 ? cdw11 :
                        ra_cmd ? cmd_view :
                        ra_stat ? stat_view :
                        ra_dw0 ? dw0 :
                        ra_atom ? {31'h00000000, normal_atomic_off} :
                        ra_aen ? {22'h000000, aen} :
                        32'h00000000;

  // ----------------------------------------
  // command execution
  // ----------------------------------------
  wire is_vec = (cmd_fid == FID_VEC_CFG);
  wire is_atom = (cmd_fid == FID_ATOMIC);
  wire is_aen = (cmd_fid == FID_ASYNC_EVT);
  wire is_known = is_vec | is_atom | is_aen;
  // reserved bits above each field are simply not looked at
  wire [VEC_IDX_W-1:0] cfg_vec = cdw11[VEC_IDX_W-1:0];
  wire cfg_off = cdw11[COAL_OFF_BIT];
  wire vec_off;
  wire vec_valid;
  wire int_vec_off;
  wire vec_bad = is_vec & ~vec_valid;
  wire tbl_wr = exec & cmd_set & is_vec & vec_valid;
  wire nao_wr = exec & cmd_set & is_atom;
  wire aen_wr = exec & cmd_set & is_aen;
  wire [7:0] ex_sc = (vec_bad | ~is_known) ? SC_INV_FIELD : SC_SUCCESS;
  wire ex_off = cmd_set ? cfg_off : vec_off;
  wire ex_nao = cmd_set ? cdw11[NAO_BIT] : normal_atomic_off;
  wire [AEN_W-1:0] ex_aen = cmd_set ? cdw11[AEN_W-1:0] : aen;
  wire [31:0] ex_dw0 = (is_vec & vec_valid) ? {15'h0000, ex_off, cfg_vec} :
                       is_atom ? {31'h00000000, ex_nao} :
                       is_aen ? {22'h000000, ex_aen} :
                       32'h00000000;

  fvec_vec_table #(
    .NUM_VEC(NUM_VEC),
    .IW(VEC_IDX_W)
  ) u_table (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .wr_en(tbl_wr),
    .wr_idx(cfg_vec),
    .wr_off(cfg_off),
    .rd_idx_a(cfg_vec),
    .cq_ok(vec_cq_ok),
    .a_off(vec_off),
    .a_valid(vec_valid),
    .rd_idx_b(int_vec),
    .b_off(int_vec_off)
  );

  // ----------------------------------------
  // interrupt decision
  // ----------------------------------------
  // admin queue, a disabled vector or a zero time all fire at once
  wire dec_now = int_admin | int_vec_off | (agg_time == 8'h00);
  wire [31:0] dec_hold = dec_now ? 32'h00000000 : 32'(agg_time) * UNIT_32;

  // ----------------------------------------
  // axi write slave
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr_q <= 5'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (ce) begin
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (b_take) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // axi read slave
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= ra_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (r_take) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // command registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cdw11 <= 32'h00000000;
    end else if (ce && wr_cdw11) begin
      cdw11 <= cdw11_merged;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      cmd_set <= 1'b0;
      cmd_fid <= 8'h00;
      done <= 1'b0;
      sc <= SC_SUCCESS;
      dw0 <= 32'h00000000;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            cmd_set <= w_data_q[CMD_SET_BIT];
            cmd_fid <= w_data_q[CMD_FID_LSB +: FID_W];
            done <= 1'b0;
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          sc <= ex_sc;
          dw0 <= ex_dw0;
          done <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // stored features
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      normal_atomic_off <= NAO_RST;
      honour_normal_atomic <= ~NAO_RST;
      aen <= AEN_RST;
    end else if (ce) begin
      if (nao_wr) begin
        normal_atomic_off <= cdw11[NAO_BIT];
        honour_normal_atomic <= ~cdw11[NAO_BIT];
      end
      if (aen_wr) begin
        aen <= cdw11[AEN_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // interrupt decision register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_go <= 1'b0;
      int_go_vec <= 16'h0000;
      int_now <= 1'b0;
      int_hold_cycles <= 32'h00000000;
    end else if (ce) begin
      int_go <= int_req;
      if (int_req) begin
        int_go_vec <= int_vec;
        int_now <= dec_now;
        int_hold_cycles <= dec_hold;
      end
    end
  end

  // ----------------------------------------
  // event gating
  // ----------------------------------------
  fvec_event_gate #(
    .CW(AEN_CW_W)
  ) u_events (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .fw_en(aen[AEN_FW_BIT]),
    .ns_en(aen[AEN_NS_BIT]),
    .cw_en(aen[AEN_CW_W-1:0]),
    .fw_evt(fw_act_evt),
    .ns_evt(ns_attr_evt),
    .cw_level(crit_warn),
    .fw_notice(fw_act_notice),
    .ns_notice(ns_attr_notice),
    .cw_notice(crit_notice)
  );

endmodule : fvec_top

// ==== tb/fvec_top_sva.sv ====
// assertion checker for the feature configuration block
`timescale 1ns/1ps
module fvec_top_sva #(
  parameter int UNIT_CYCLES = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // interrupt path
  input wire logic int_req,
  input wire logic [fvec_pkg::VEC_IDX_W-1:0] int_vec,
  input wire logic int_admin,
  input wire logic [7:0] agg_time,
  input wire logic int_go,
  input wire logic [fvec_pkg::VEC_IDX_W-1:0] int_go_vec,
  input wire logic int_now,
  input wire logic [31:0] int_hold_cycles,
  // atomicity and events
  input wire logic normal_atomic_off,
  input wire logic honour_normal_atomic,
  input wire logic fw_act_evt,
  input wire logic ns_attr_evt,
  input wire logic [fvec_pkg::AEN_CW_W-1:0] crit_warn,
  input wire logic fw_act_notice,
  input wire logic ns_attr_notice,
  input wire logic [fvec_pkg::AEN_CW_W-1:0] crit_notice
);
  import fvec_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_go_pulse: assert property (ce |=> int_go == $past(int_req))
    else $error("int_go does not follow int_req");
  a_vec_echo: assert property (int_req && ce |=> int_go_vec == $past(int_vec))
    else $error("int_go_vec differs from requested vector");
  a_admin_now: assert property (ce && int_req && int_admin |=>
    int_now && int_hold_cycles == 0)
    else $error("admin interrupt was delayed");
  a_zero_time: assert property (ce && int_req && agg_time == 8'h00 |=> int_now)
    else $error("zero time still delayed");
  // hold is the 100 us unit scaled down by the parameter
  a_hold_calc: assert property (int_go && !int_now |->
    int_hold_cycles == 32'(UNIT_CYCLES) * 32'($past(agg_time)))
    else $error("hold cycles wrong");
  a_atom_pair: assert property (honour_normal_atomic != normal_atomic_off)
    else $error("atomicity outputs disagree");
  a_fw_gate: assert property (fw_act_notice |-> $past(fw_act_evt))
    else $error("firmware notice without event");
  a_ns_gate: assert property (ns_attr_notice |-> $past(ns_attr_evt))
    else $error("namespace notice without event");
  a_crit_rise: assert property ((crit_notice & ~($past(crit_warn) & ~$past(crit_warn, 2))) == 8'h00)
    else $error("critical notice without rising warning");
endmodule : fvec_top_sva

bind fvec_top fvec_top_sva #(.UNIT_CYCLES(UNIT_CYCLES)) u_sva (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .int_req(int_req), .int_vec(int_vec),
  .int_admin(int_admin), .agg_time(agg_time), .int_go(int_go), .int_go_vec(int_go_vec),
  .int_now(int_now), .int_hold_cycles(int_hold_cycles),
  .normal_atomic_off(normal_atomic_off), .honour_normal_atomic(honour_normal_atomic),
  .fw_act_evt(fw_act_evt), .ns_attr_evt(ns_attr_evt), .crit_warn(crit_warn),
  .fw_act_notice(fw_act_notice), .ns_attr_notice(ns_attr_notice), .crit_notice(crit_notice)
);

// ==== tb/fvec_host.sv ====
// host model issuing feature commands over axi4-lite
`timescale 1ns/1ps
module fvec_host (
  // clock
  input wire logic aclk,
  // write channels
  output logic awvalid,
  input wire logic awready,
  output logic [4:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // read channels
  output logic arvalid,
  input wire logic arready,
  output logic [4:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  import fvec_pkg::*;
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb} = 14'h0000;
    wdata = 32'h0;
  end
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // dword 11 first, then go; polling is slow but never misses done
  task automatic cmd(input logic set, input logic [7:0] fid, input logic [31:0] c11,
                     output logic [7:0] code, output logic [31:0] dw0);
    logic [1:0] r;
    logic [31:0] s;
    wr(ADDR_CDW11, c11, r);
    wr(ADDR_CMD, {16'h0000, fid, 6'h00, set, 1'b1}, r);
    s = 32'h0;
    while (s[0] !== 1'b1) rd(ADDR_STAT, s, r);
    code = s[15:8];
    rd(ADDR_DW0, dw0, r);
  endtask : cmd
endmodule : fvec_host

// ==== tb/fvec_top_tb.sv ====
// self-checking bench for the feature configuration block
`timescale 1ns/1ps
module fvec_top_tb;
  import fvec_pkg::*;
  typedef struct packed {
    logic set;
    logic [7:0] fid;
    logic [31:0] c11;
    logic [7:0] code;
    logic [31:0] dw0;
  } fvec_row_t;
  localparam int UNIT = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [4:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [31:0] wdata, rdata, int_hold_cycles, dw0;
  logic [1:0] bresp, rresp, r;
  logic [7:0] code;
  logic [31:0] vec_cq_ok = 32'hffff_ffdf;
  logic int_req = 1'b0;
  logic int_admin = 1'b0;
  logic [15:0] int_vec = 16'h0000;
  logic [15:0] int_go_vec;
  logic [7:0] agg_time = 8'h00;
  logic fw_act_evt = 1'b0;
  logic ns_attr_evt = 1'b0;
  logic [7:0] crit_warn = 8'h00;
  logic [7:0] crit_notice;
  logic int_go, int_now, normal_atomic_off, honour_normal_atomic, fw_act_notice, ns_attr_notice;
  int n_errors = 0;
  int num_checks = 0;
  // vector 5 has no queue, vector 0x28 is out of range
  fvec_row_t rows [12] = '{
    '{1'b0, 8'h09, 32'h3, 8'h00, 32'h3}, '{1'b1, 8'h09, 32'hffff_0003, 8'h00, 32'h1_0003},
    '{1'b1, 8'h09, 32'h28, 8'h02, 32'h0}, '{1'b0, 8'h09, 32'h5, 8'h02, 32'h0},
    '{1'b0, 8'h09, 32'h3, 8'h00, 32'h1_0003}, '{1'b0, 8'h0a, 32'h0, 8'h00, 32'h0},
    '{1'b1, 8'h0a, 32'hffff_fffe, 8'h00, 32'h0}, '{1'b1, 8'h0a, 32'h1, 8'h00, 32'h1},
    '{1'b0, 8'h0a, 32'h0, 8'h00, 32'h1}, '{1'b1, 8'h0b, 32'hffff_fd55, 8'h00, 32'h155},
    '{1'b0, 8'h0b, 32'h0, 8'h00, 32'h155}, '{1'b1, 8'h08, 32'h1, 8'h02, 32'h0}};

  always #2.5 aclk = ~aclk;

  fvec_top #(.NUM_VEC(32), .UNIT_CYCLES(UNIT)) uut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .vec_cq_ok(vec_cq_ok), .int_req(int_req), .int_vec(int_vec), .int_admin(int_admin),
    .agg_time(agg_time), .int_go(int_go), .int_go_vec(int_go_vec), .int_now(int_now),
    .int_hold_cycles(int_hold_cycles), .normal_atomic_off(normal_atomic_off),
    .honour_normal_atomic(honour_normal_atomic), .fw_act_evt(fw_act_evt),
    .ns_attr_evt(ns_attr_evt), .crit_warn(crit_warn), .fw_act_notice(fw_act_notice),
    .ns_attr_notice(ns_attr_notice), .crit_notice(crit_notice));

  fvec_host host (
    .aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic irq(input logic [15:0] v, input logic adm, input logic [7:0] t,
                     input logic now, input logic [31:0] hold);
    @(posedge aclk);
    int_req <= 1'b1;
    int_vec <= v;
    int_admin <= adm;
    agg_time <= t;
    @(posedge aclk);
    int_req <= 1'b0;
    #1;
    chk("int_go", {31'h0, int_go}, 32'h1);
    chk("int_go_vec", {16'h0, int_go_vec}, {16'h0, v});
    chk("int_now", {31'h0, int_now}, {31'h0, now});
    chk("hold", int_hold_cycles, hold);
  endtask : irq
  task automatic ev(input logic fw, input logic ns, input logic [7:0] cw);
    @(posedge aclk);
    fw_act_evt <= fw;
    ns_attr_evt <= ns;
    crit_warn <= cw;
    @(posedge aclk);
    fw_act_evt <= 1'b0;
    ns_attr_evt <= 1'b0;
    #1;
  endtask : ev
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  // generous: the whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    host.rd(ADDR_AEN, dw0, r);
    chk("aen reset", dw0, 32'h0);
    chk("honour reset", {31'h0, honour_normal_atomic}, 32'h1);
    host.rd(5'h18, dw0, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    chk("unmapped data", dw0, 32'h0);
    foreach (rows[i]) begin
      host.cmd(rows[i].set, rows[i].fid, rows[i].c11, code, dw0);
      chk("row code", {24'h0, code}, {24'h0, rows[i].code});
      chk("row dw0", dw0, rows[i].dw0);
    end
    chk("atomic off", {31'h0, normal_atomic_off}, 32'h1);
    host.wr(ADDR_ATOM, 32'h0, r);
    chk("atom wr resp", {30'h0, r}, {30'h0, RESP_OKAY});
    host.rd(ADDR_ATOM, dw0, r);
    chk("atom kept", dw0, 32'h1);
    irq(16'h3, 1'b0, 8'h05, 1'b1, 32'h0);
    irq(16'h1, 1'b0, 8'h05, 1'b0, 32'(5 * UNIT));
    irq(16'h1, 1'b1, 8'h05, 1'b1, 32'h0);
    irq(16'h1, 1'b0, 8'h00, 1'b1, 32'h0);
    // a request while the enable is low must leave the decision frozen
    @(posedge aclk);
    ce <= 1'b0;
    int_req <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    chk("ce freeze", {31'h0, int_go}, 32'h0);
    @(posedge aclk);
    ce <= 1'b1;
    int_req <= 1'b0;
    ev(1'b1, 1'b1, 8'hff);
    chk("fw off", {31'h0, fw_act_notice}, 32'h0);
    chk("ns on", {31'h0, ns_attr_notice}, 32'h1);
    chk("crit rise", {24'h0, crit_notice}, 32'h55);
    @(posedge aclk);
    crit_warn <= 8'h00;
    #1;
    chk("crit level", {24'h0, crit_notice}, 32'h0);
    host.cmd(1'b1, FID_ASYNC_EVT, 32'h200, code, dw0);
    ev(1'b1, 1'b1, 8'h01);
    chk("fw on", {31'h0, fw_act_notice}, 32'h1);
    chk("ns off", {31'h0, ns_attr_notice}, 32'h0);
    chk("crit off", {24'h0, crit_notice}, 32'h0);
    @(posedge aclk);
    crit_warn <= 8'h00;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    host.cmd(1'b0, FID_VEC_CFG, 32'h3, code, dw0);
    chk("vec after reset", dw0, 32'h3);
    chk("atomic after reset", {31'h0, normal_atomic_off}, 32'h0);
    complete_run();
  end
endmodule : fvec_top_tb
